// ---- rtl/stepper_drive_current_io_control.sv ----
// Local design decisions: strobed register access and the placing of the registers.
`include "stepper_drive_defines.svh"

// Notes on behaviour
// - Primary damping gain zero disables damping.
// - Secondary gain 0.1 to 25.0, primary nonzero.
// - Separate interpolation and smoothing enables.
// - Smoothing gain 20 to 2621, 2621 inactive.
// - Interpolation forces fixed smoothing gain.
// - Stop timeout cuts current by 25 percent.
// - Next step restores full current.
// - Stop timeout 0 to 19656 ms, zero off.
// - Idle timeout 0 to 3600 s, zero off.
// - Idle timeout cuts by configured percentage.
// - Idle percentage preferred over stop reduction.
// - Stall detector only at 0.5 rps up.
// - Four assignable inputs, one assignable output.
// - Jog inputs drive motor while asserted.
// - Jog speed input selects high velocity.
// - Stop input requests deceleration at stop rate.
// - Halt input ends motion immediately.
// - Reserved input acts as unassigned.
// - Move select bits form index; restart input.
// - Fault hold output follows fault.
// - Moving output shows steps or engine.
// - Lost sync output shows detected stall.
module stepper_drive_current_io_control
  import stepper_drive_pkg::*;
#(
  parameter int MS_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
)(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port.
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [31:0] rdata_o,
  // Motion and drive status.
  input wire logic step_i,
  input wire logic engine_busy_i,
  input wire logic [15:0] velocity_i,
  input wire logic fault_i,
  input wire logic stall_i,
  input wire logic [3:0] din_i,
  // Tuning outputs.
  output logic damping_enable_o,
  output logic [14:0] damping_primary_gain_o,
  output logic [7:0] damping_secondary_gain_o,
  output logic adaptive_smoothing_enable_o,
  output logic [11:0] adaptive_smoothing_gain_o,
  output logic encoderless_stall_detector_o,
  output logic [6:0] current_scale_o,
  // Input function outputs.
  output logic jog_pos_o,
  output logic jog_neg_o,
  output logic jog_high_speed_o,
  output logic stop_req_o,
  output logic halt_req_o,
  output logic travel_limit_input_o,
  output logic [3:0] move_index_o,
  output logic warm_restart_o,
  // Assignable output.
  output logic dig_out_o
);

  // ==========================================
  // Configuration registers.
  logic interp_en_q;
  logic smooth_en_q;
  logic stall_en_q;
  logic [14:0] damp1_q;
  logic [7:0] damp2_q;
  logic [11:0] smgain_q;
  logic [14:0] stop_to_q;
  logic [11:0] idle_to_q;
  logic [6:0] idle_pct_q;
  in_func_t in_sel_q [4];
  out_func_t out_sel_q;
  logic [31:0] rdata_q;
  logic [31:0] status;

  // Register writes; secondary and smoothing gains are clamped into their legal ranges.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      interp_en_q <= 1'b0;
      smooth_en_q <= 1'b0;
      stall_en_q <= 1'b0;
      damp1_q <= `RST_DAMP1;
      damp2_q <= `RST_DAMP2;
      smgain_q <= `RST_SMGAIN;
      stop_to_q <= 15'h0000;
      idle_to_q <= 12'h000;
      idle_pct_q <= 7'h00;
      out_sel_q <= OUT_NONE;
      for (int i = 0; i < 4; i++)
        in_sel_q[i] <= IN_NONE;
    end
    else if (we_i)
    begin
      unique case (addr_i)
        `OFS_CTRL:
        begin
          interp_en_q <= wdata_i[`CTRL_INTERP_BIT];
          smooth_en_q <= wdata_i[`CTRL_SMOOTH_BIT];
          stall_en_q <= wdata_i[`CTRL_STALL_BIT];
        end
        `OFS_DAMP1: damp1_q <= wdata_i[14:0];
        `OFS_DAMP2:
          damp2_q <= (wdata_i[7:0] < `DAMP2_MIN) ? `DAMP2_MIN :
                     (wdata_i[7:0] > `DAMP2_MAX) ? `DAMP2_MAX : wdata_i[7:0];
        `OFS_SMGAIN:
          smgain_q <= (wdata_i[11:0] < `SMGAIN_MIN) ? `SMGAIN_MIN :
                      (wdata_i[11:0] > `SMGAIN_MAX) ? `SMGAIN_MAX : wdata_i[11:0];
        `OFS_STOP_TO:
          stop_to_q <= (wdata_i[14:0] > `STOP_TO_MAX) ? `STOP_TO_MAX : wdata_i[14:0];
        `OFS_IDLE_TO:
          idle_to_q <= (wdata_i[11:0] > `IDLE_TO_MAX) ? `IDLE_TO_MAX : wdata_i[11:0];
        `OFS_IDLE_PCT:
          idle_pct_q <= (wdata_i[6:0] > `PCT_FULL) ? `PCT_FULL : wdata_i[6:0];
        `OFS_IN_SEL:
          for (int i = 0; i < 4; i++)
            in_sel_q[i] <= in_func_t'(wdata_i[4*i +: 4]);
        `OFS_OUT_SEL: out_sel_q <= out_func_t'(wdata_i[2:0]);
        default: ;
      endcase
    end
  end

  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge clk_i)
  begin
    if (reset_i || !re_i)
      rdata_q <= 32'h0000_0000;
    else
    begin
      unique case (addr_i)
        `OFS_CTRL: rdata_q <= {29'h0, stall_en_q, smooth_en_q, interp_en_q};
        `OFS_DAMP1: rdata_q <= {17'h0, damp1_q};
        `OFS_DAMP2: rdata_q <= {24'h0, damp2_q};
        `OFS_SMGAIN: rdata_q <= {20'h0, smgain_q};
        `OFS_STOP_TO: rdata_q <= {17'h0, stop_to_q};
        `OFS_IDLE_TO: rdata_q <= {20'h0, idle_to_q};
        `OFS_IDLE_PCT: rdata_q <= {25'h0, idle_pct_q};
        `OFS_IN_SEL: rdata_q <= {16'h0, in_sel_q[3], in_sel_q[2], in_sel_q[1], in_sel_q[0]};
        `OFS_OUT_SEL: rdata_q <= {29'h0, out_sel_q};
        `OFS_STATUS: rdata_q <= status;
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign rdata_o = rdata_q;

  // ==========================================
  // Tuning outputs follow the configuration.
  assign damping_enable_o = (damp1_q != 15'h0000);
  assign damping_primary_gain_o = damp1_q;
  assign damping_secondary_gain_o = damping_enable_o ? damp2_q : 8'h00;
  assign adaptive_smoothing_gain_o = interp_en_q ? `SMGAIN_FIXED : smgain_q;
  assign adaptive_smoothing_enable_o = smooth_en_q &&
                                       (adaptive_smoothing_gain_o != `SMGAIN_MAX);
  assign encoderless_stall_detector_o = stall_en_q && (velocity_i >= `STALL_MIN_VEL);

  // ==========================================
  // Quiet-time counters, all restarted by a step.
  logic [16:0] tick_q;
  logic [14:0] quiet_ms_q;
  logic [9:0] sub_ms_q;
  logic [11:0] quiet_s_q;
  logic ms_tick;
  logic s_tick;
  assign ms_tick = !step_i && (tick_q == 17'(MS_CYCLES - 1));
  assign s_tick = ms_tick && (sub_ms_q == `MS_PER_SEC);

  // Millisecond prescaler.
  always_ff @(posedge clk_i)
  begin
    if (reset_i || step_i || ms_tick)
      tick_q <= 17'h00000;
    else
      tick_q <= tick_q + 17'h00001;
  end

  // Milliseconds since the last step, saturating.
  always_ff @(posedge clk_i)
  begin
    if (reset_i || step_i)
      quiet_ms_q <= 15'h0000;
    else if (ms_tick && quiet_ms_q != 15'h7fff)
      quiet_ms_q <= quiet_ms_q + 15'h0001;
  end

  // Milliseconds within the current second.
  always_ff @(posedge clk_i)
  begin
    if (reset_i || step_i || s_tick)
      sub_ms_q <= 10'h000;
    else if (ms_tick)
      sub_ms_q <= sub_ms_q + 10'h001;
  end

  // Seconds since the last step, saturating.
  always_ff @(posedge clk_i)
  begin
    if (reset_i || step_i)
      quiet_s_q <= 12'h000;
    else if (s_tick && quiet_s_q != 12'hfff)
      quiet_s_q <= quiet_s_q + 12'h001;
  end

  // ==========================================
  // Reduction stage and current scale in percent of full.
  red_stage_t stage_d;
  red_stage_t stage_q;
  logic [6:0] scale_d;
  logic stop_on;
  logic idle_on;
  assign stop_on = (stop_to_q != 15'h0000);
  assign idle_on = (idle_to_q != 12'h000);

  // Idle is checked first so its percentage wins.
  always_comb
  begin
    if (step_i)
      stage_d = RED_FULL;
    else if (idle_on && quiet_s_q >= idle_to_q)
      stage_d = RED_IDLE;
    else if (stop_on && quiet_ms_q >= stop_to_q)
      stage_d = RED_STOP;
    else
      stage_d = RED_FULL;
    unique case (stage_d)
      RED_IDLE: scale_d = `PCT_FULL - idle_pct_q;
      RED_STOP: scale_d = `PCT_STOP;
      default: scale_d = `PCT_FULL;
    endcase
  end

  // Stage and scale update together.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      stage_q <= RED_FULL;
      current_scale_o <= `PCT_FULL;
    end
    else
    begin
      stage_q <= stage_d;
      current_scale_o <= scale_d;
    end
  end

  // Status word read by software.
  assign status = {20'h0, move_index_o, 2'b00, !idle_on, !stop_on,
                   encoderless_stall_detector_o, damping_enable_o,
                   stage_q == RED_IDLE, stage_q == RED_STOP};

  // ==========================================
  // Digital input function decode.
  logic [3:0] hit_jp;
  logic [3:0] hit_jn;
  logic [3:0] hit_js;
  logic [3:0] hit_st;
  logic [3:0] hit_ht;
  logic [3:0] hit_tl;
  logic [3:0] hit_ms;
  logic [3:0] hit_wr;

  // Reserved and unassigned codes match nothing.
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      hit_jp[i] = din_i[i] && in_sel_q[i] == IN_JOG_POS;
      hit_jn[i] = din_i[i] && in_sel_q[i] == IN_JOG_NEG;
      hit_js[i] = din_i[i] && in_sel_q[i] == IN_JOG_SPEED;
      hit_st[i] = din_i[i] && in_sel_q[i] == IN_STOP;
      hit_ht[i] = din_i[i] && in_sel_q[i] == IN_HALT;
      hit_tl[i] = din_i[i] && in_sel_q[i] == IN_TRAVEL_LIMIT;
      hit_ms[i] = din_i[i] && in_sel_q[i] == IN_MOVE_SEL;
      hit_wr[i] = din_i[i] && in_sel_q[i] == IN_WARM_RESTART;
    end
  end

  // Registered function requests.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      jog_pos_o <= 1'b0;
      jog_neg_o <= 1'b0;
      jog_high_speed_o <= 1'b0;
      stop_req_o <= 1'b0;
      halt_req_o <= 1'b0;
      travel_limit_input_o <= 1'b0;
      move_index_o <= 4'h0;
      warm_restart_o <= 1'b0;
    end
    else
    begin
      jog_pos_o <= |hit_jp;
      jog_neg_o <= |hit_jn;
      jog_high_speed_o <= |hit_js;
      stop_req_o <= |hit_st;
      halt_req_o <= |hit_ht;
      travel_limit_input_o <= |hit_tl;
      move_index_o <= hit_ms;
      warm_restart_o <= |hit_wr;
    end
  end

  // ==========================================
  // Assignable output.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      dig_out_o <= 1'b0;
    else
    begin
      unique case (out_sel_q)
        OUT_FAULT_HOLD: dig_out_o <= fault_i;
        OUT_MOVING: dig_out_o <= engine_busy_i || step_i;
        OUT_LOST_SYNC: dig_out_o <= stall_i && encoderless_stall_detector_o;
        default: dig_out_o <= 1'b0;
      endcase
    end
  end

  // ==========================================
  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_step;
    step_i;
  endsequence

  sequence s_quiet_tick;
    !step_i && ms_tick;
  endsequence

  a_damp_gate_off: assert property ((damp1_q == 15'h0000) |->
    !damping_enable_o && damping_secondary_gain_o == 8'h00)
    else $error("Damping active with zero primary gain.");
  a_damp2_range: assert property (damping_enable_o |->
    damping_secondary_gain_o >= `DAMP2_MIN && damping_secondary_gain_o <= `DAMP2_MAX)
    else $error("Secondary gain out of range.");
  a_smooth_fixed_gain: assert property (interp_en_q |->
    adaptive_smoothing_gain_o == `SMGAIN_FIXED)
    else $error("Smoothing gain not fixed under interpolation.");
  a_step_full_current: assert property (s_step |=>
    current_scale_o == `PCT_FULL && stage_q == RED_FULL)
    else $error("Current not restored after step.");
  // The stage lags the timeout registers by one cycle, so the enables are taken one cycle back.
  a_stop_scale: assert property ((stage_q == RED_STOP) |->
    current_scale_o == `PCT_STOP && $past(stop_on))
    else $error("Stop reduction wrong.");
  a_idle_off_zero: assert property (!$past(idle_on) |-> stage_q != RED_IDLE)
    else $error("Idle reduction while disabled.");
  a_stall_gate_vel: assert property (encoderless_stall_detector_o |->
    velocity_i >= `STALL_MIN_VEL && stall_en_q)
    else $error("Stall detector on below threshold.");
  a_quiet_restart: assert property (s_step |=> quiet_ms_q == 15'h0000
    && quiet_s_q == 12'h000 && tick_q == 17'h00000)
    else $error("Quiet counters not restarted.");
  a_quiet_ms_count: assert property (s_quiet_tick ##0 quiet_ms_q != 15'h7fff |=>
    quiet_ms_q == $past(quiet_ms_q) + 15'h0001)
    else $error("Quiet millisecond count missed a tick.");
  a_jog_follow: assert property ((|hit_jp) |=> jog_pos_o)
    else $error("Jog request missed.");
  a_halt_follow: assert property ((|hit_ht) |=> halt_req_o)
    else $error("Halt request missed.");
endmodule // stepper_drive_current_io_control

// ---- rtl/stepper_drive_defines.svh ----
`ifndef STEPPER_DRIVE_DEFINES_SVH
`define STEPPER_DRIVE_DEFINES_SVH
// ==========================================
// Register byte offsets.
`define OFS_CTRL 8'h00
`define OFS_DAMP1 8'h04
`define OFS_DAMP2 8'h08
`define OFS_SMGAIN 8'h0c
`define OFS_STOP_TO 8'h10
`define OFS_IDLE_TO 8'h14
`define OFS_IDLE_PCT 8'h18
`define OFS_IN_SEL 8'h1c
`define OFS_OUT_SEL 8'h20
`define OFS_STATUS 8'h24
// ==========================================
// Control register bit positions.
`define CTRL_INTERP_BIT 0
`define CTRL_SMOOTH_BIT 1
`define CTRL_STALL_BIT 2
// ==========================================
// Reset values and limits.
`define RST_DAMP1 15'h0000
`define RST_DAMP2 8'h0a
`define DAMP2_MIN 8'h01
`define DAMP2_MAX 8'hfa
`define RST_SMGAIN 12'ha3d
`define SMGAIN_MIN 12'h014
`define SMGAIN_MAX 12'ha3d
`define SMGAIN_FIXED 12'h200
`define STOP_TO_MAX 15'h4cc8
`define IDLE_TO_MAX 12'he10
`define PCT_FULL 7'h64
`define PCT_STOP 7'h4b
`define STALL_MIN_VEL 16'h0032
// ==========================================
// Timing.
`define CLK_PERIOD_NS 8
`define TICK_PERIOD_NS 1000000
`define MS_PER_SEC 10'h3e7
`endif

// ---- rtl/stepper_drive_pkg.sv ----
package stepper_drive_pkg;
  // ==========================================
  // Current reduction stage.
  typedef enum logic [1:0] {
    RED_FULL = 2'b00,
    RED_STOP = 2'b01,
    RED_IDLE = 2'b10
  } red_stage_t;
  // ==========================================
  // Digital input functions.
  typedef enum logic [3:0] {
    IN_NONE = 4'b0000,
    IN_JOG_POS = 4'b0001,
    IN_JOG_NEG = 4'b0010,
    IN_JOG_SPEED = 4'b0011,
    IN_STOP = 4'b0100,
    IN_HALT = 4'b0101,
    IN_TRAVEL_LIMIT = 4'b0110,
    IN_RESERVED = 4'b0111,
    IN_MOVE_SEL = 4'b1000,
    IN_WARM_RESTART = 4'b1001
  } in_func_t;
  // ==========================================
  // Digital output functions.
  typedef enum logic [2:0] {
    OUT_NONE = 3'b000,
    OUT_FAULT_HOLD = 3'b001,
    OUT_MOVING = 3'b010,
    OUT_RESERVED = 3'b011,
    OUT_LOST_SYNC = 3'b100
  } out_func_t;
endpackage

// ---- test/step_source_model.sv ----
// ==========================================
// Far-side step source: emits a burst of one-cycle step pulses.
module step_source_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Burst request.
  input wire logic kick_i,
  input wire logic [7:0] n_steps_i,
  // Step stream.
  output logic step_o,
  output logic engine_busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_q;
  logic phase_q;
  // Steps are spaced two cycles apart, as a real pulse train never holds the line high.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      left_q <= 8'h00;
      phase_q <= 1'b0;
      step_o <= 1'b0;
    end
    else if (kick_i)
    begin
      left_q <= n_steps_i;
      phase_q <= 1'b0;
      step_o <= 1'b0;
    end
    else
    begin
      phase_q <= ~phase_q;
      step_o <= (left_q != 8'h00) && !phase_q;
      if ((left_q != 8'h00) && !phase_q)
        left_q <= left_q - 8'h01;
    end
  end
  // The engine counts as busy while pulses remain.
  assign engine_busy_o = (left_q != 8'h00);
endmodule // step_source_model

// ---- test/tb_top.sv ----
`include "stepper_drive_defines.svh"
module tb_top
  import stepper_drive_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS_SIM = 10;
  logic clk_i = 1'b0, reset_i = 1'b1, we_i = 1'b0, re_i = 1'b0, kick = 1'b0;
  logic fault_i = 1'b0, stall_i = 1'b0, step_w, busy_w, dig_out_o;
  logic [7:0] addr_i = 8'h00, n_steps = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, rd;
  logic [15:0] velocity_i = 16'h0000;
  logic [3:0] din_i = 4'h0, move_index_o;
  logic damp_en, smooth_en, stall_en, jp, jn, jhs, stp, hlt, tlim, warm;
  logic [14:0] damp1;
  logic [7:0] damp2;
  logic [11:0] smgain;
  logic [6:0] scale;
  int n_fail = 0, checks_done = 0, cycles = 0;
  // ==========================================
  // Clock, design and far side.
  always #4 clk_i = ~clk_i;
  stepper_drive_current_io_control #(.MS_CYCLES(MS_SIM)) uut (.clk_i(clk_i),
    .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
    .rdata_o(rdata_o), .step_i(step_w), .engine_busy_i(busy_w), .velocity_i(velocity_i),
    .fault_i(fault_i), .stall_i(stall_i), .din_i(din_i), .damping_enable_o(damp_en),
    .damping_primary_gain_o(damp1), .damping_secondary_gain_o(damp2),
    .adaptive_smoothing_enable_o(smooth_en), .adaptive_smoothing_gain_o(smgain),
    .encoderless_stall_detector_o(stall_en), .current_scale_o(scale), .jog_pos_o(jp),
    .jog_neg_o(jn), .jog_high_speed_o(jhs), .stop_req_o(stp), .halt_req_o(hlt),
    .travel_limit_input_o(tlim), .move_index_o(move_index_o), .warm_restart_o(warm),
    .dig_out_o(dig_out_o));
  step_source_model src (.clk_i(clk_i), .reset_i(reset_i), .kick_i(kick),
    .n_steps_i(n_steps), .step_o(step_w), .engine_busy_o(busy_w));
  // ==========================================
  // Shared tasks.
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
    #1;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 rd = rdata_o;
  endtask
  task automatic steps(input logic [7:0] n);
    @(posedge clk_i);
    kick <= 1'b1;
    n_steps <= n;
    @(posedge clk_i);
    kick <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Hang guard.
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles > 40000)
    begin
      n_fail++;
      close_out();
    end
  end
  // ==========================================
  // Main sequence.
  initial
  begin
    logic [7:0] exp_fn;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rdr(`OFS_DAMP2);
    chk(rd, 32'h0000000a);
    rdr(`OFS_SMGAIN);
    chk(rd, 32'h00000a3d);
    chk(scale, 32'h64);
    // Damping gains.
    wr(`OFS_DAMP2, 32'h00000064);
    chk({damp_en, damp2}, 32'h0);
    wr(`OFS_DAMP1, 32'h00007fff);
    chk({damp_en, damp1, damp2}, {1'b1, 15'h7fff, 8'h64});
    wr(`OFS_DAMP2, 32'h00000000);
    chk(damp2, 32'h01);
    wr(`OFS_DAMP2, 32'h000000ff);
    chk(damp2, 32'hfa);
    // Smoothing and interpolation.
    wr(`OFS_CTRL, 32'h00000002);
    chk(smooth_en, 32'h0);
    wr(`OFS_SMGAIN, 32'h00000064);
    chk({smooth_en, smgain}, {1'b1, 12'h064});
    wr(`OFS_SMGAIN, 32'h00000005);
    chk(smgain, 32'h014);
    wr(`OFS_CTRL, 32'h00000003);
    chk({smooth_en, smgain}, {1'b1, 12'h200});
    // Stall detector threshold.
    wr(`OFS_CTRL, 32'h00000004);
    velocity_i <= 16'h0031;
    cyc(1);
    chk(stall_en, 32'h0);
    velocity_i <= 16'h0032;
    cyc(1);
    chk(stall_en, 32'h1);
    // Timeouts off leave full current.
    wr(`OFS_STOP_TO, 32'h0);
    wr(`OFS_IDLE_TO, 32'h0);
    steps(8'h01);
    cyc(80);
    chk(scale, 32'h64);
    rdr(`OFS_STATUS);
    chk(rd[5:0], 32'h3c);
    // Stop stage, step restart, idle precedence.
    wr(`OFS_STOP_TO, 32'h00000003);
    steps(8'h01);
    cyc(20);
    steps(8'h01);
    cyc(22);
    chk(scale, 32'h64);
    cyc(20);
    chk(scale, 32'h4b);
    steps(8'h01);
    cyc(3);
    chk(scale, 32'h64);
    wr(`OFS_IDLE_PCT, 32'h0000007f);
    rdr(`OFS_IDLE_PCT);
    chk(rd, 32'h64);
    wr(`OFS_IDLE_PCT, 32'h00000028);
    wr(`OFS_IDLE_TO, 32'h00000001);
    steps(8'h01);
    cyc(10100);
    chk(scale, 32'h3c);
    steps(8'h02);
    cyc(3);
    chk(scale, 32'h64);
    // Input functions on all four inputs.
    din_i <= 4'hf;
    for (int c = 0; c < 10; c++)
    begin
      wr(`OFS_IN_SEL, {16'h0, {4{c[3:0]}}});
      cyc(2);
      exp_fn = 8'h00;
      if (c >= 1 && c <= 6)
        exp_fn[c-1] = 1'b1;
      if (c == 9)
        exp_fn[6] = 1'b1;
      chk({warm, tlim, hlt, stp, jhs, jn, jp}, exp_fn);
      chk(move_index_o, (c == 8) ? 32'hf : 32'h0);
    end
    din_i <= 4'h2;
    wr(`OFS_IN_SEL, 32'h00008888);
    cyc(2);
    chk(move_index_o, 32'h2);
    wr(`OFS_IN_SEL, 32'h00000070);
    cyc(2);
    chk({warm, tlim, hlt, stp, jhs, jn, jp, move_index_o}, 32'h0);
    // Output functions.
    fault_i <= 1'b1;
    stall_i <= 1'b1;
    for (int c = 0; c < 5; c++)
    begin
      wr(`OFS_OUT_SEL, c);
      cyc(2);
      chk(dig_out_o, (c == 1 || c == 4) ? 32'h1 : 32'h0);
    end
    stall_i <= 1'b0;
    cyc(2);
    chk(dig_out_o, 32'h0);
    wr(`OFS_OUT_SEL, 32'h00000002);
    cyc(2);
    chk(dig_out_o, 32'h0);
    steps(8'h04);
    cyc(3);
    chk(dig_out_o, 32'h1);
    cyc(20);
    chk(dig_out_o, 32'h0);
    close_out();
  end
endmodule // tb_top
